// ==== pkg/interval_timer_cfg.svh ====
// register offsets, field positions, reset values and counts for the interval timer
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_TIMER_CONTROL   12'h000
`define OFS_PERIOD_VALUE    12'h004
`define OFS_COUNT_VALUE     12'h008
`define OFS_IRQ_STATUS      12'h00c
`define OFS_IRQ_MASK        12'h010
`define OFS_IRQ_CONFIG      12'h014
`define OFS_POWER_STATE     12'h018

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define POS_RUN             15
`define POS_IDLE_HALT       13
`define POS_GATED           6
`define POS_PRESCALE_HI     5
`define POS_PRESCALE_LO     4
`define POS_SYNC            2
`define POS_CLK_SRC         1
`define CONTROL_WMASK       16'ha076

// ----------------------------------------------------------------------------
// status bits, reset values, counts
// ----------------------------------------------------------------------------
`define POS_ST_MATCH        0
`define POS_ST_GATE_FALL    1
`define RST_CONTROL         16'h0000
`define RST_PERIOD          16'hffff
`define RST_COUNT           16'h0000
`define DIV_1_TERM          8'h00
`define DIV_8_TERM          8'h07
`define DIV_64_TERM         8'h3f
`define DIV_256_TERM        8'hff

`endif

// ==== pkg/interval_timer_pkg.sv ====
// types shared by the interval timer files
package interval_timer_pkg;
	typedef struct packed {
		logic       run;
		logic       idle_halt;
		logic       gated;
		logic [1:0] prescale;
		logic       sync;
		logic       clk_src;
	} timer_ctrl_t;

	typedef struct packed {
		logic idle;
		logic sleep;
	} power_state_t;

	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_EXT_SYNC,
		SRC_EXT_ASYNC
	} count_src_t;
endpackage

// ==== rtl/pin_sync3.sv ====
// three flop synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module pin_sync3 (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic [2:0] stage;

	// first stage is read only by the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage <= 3'h0;
		end else begin
			stage <= {stage[1:0], pin};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			rise <= 1'b0;
			fall <= 1'b0;
			if (stage[1] == stage[2] && stage[2] != level) begin
				level <= stage[2];
				rise  <= stage[2];
				fall  <= !stage[2];
			end
		end
	end
endmodule

// ==== rtl/prescaler.sv ====
// prescale divider producing one-cycle count ticks
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"
module prescaler
	import interval_timer_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] prescale,
	output logic            tick_out
);
	logic [7:0] div_count;
	logic [7:0] term;

	always_comb begin
		case (prescale)
			2'h0:    term = `DIV_1_TERM;
			2'h1:    term = `DIV_8_TERM;
			2'h2:    term = `DIV_64_TERM;
			default: term = `DIV_256_TERM;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			div_count <= 8'h00;
			tick_out  <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (clear) begin
				div_count <= 8'h00;
			end else if (tick_in) begin
				if (div_count >= term) begin
					div_count <= 8'h00;
					tick_out  <= 1'b1;
				end else begin
					div_count <= div_count + 8'h01;
				end
			end
		end
	end
endmodule

// ==== rtl/interval_timer.sv ====
// interval timer top: apb registers, count, period match and interrupt
//
// How it works
// R1: sixteen bit count, three clocking modes
// R2: interrupt on match or gate falling edge
// R3: run bit fifteen starts and stops
// R4: idle halt bit thirteen stops in idle
// R5: gated bit six counts while gate high
// R6: prescale bits five four select divide
// R7: sync bit two synchronises external clock
// R8: clock source bit one picks pin
// R9: writable period compared with count
// R10: enable gates request, carries priority
// R11: may count through idle and sleep
// R12: free running repeated interval operation
// R13: software selects sync before external use
// R14: match clears count, flags one event
// R15: gate ignored on external, unused bits zero
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"
module interval_timer
	import interval_timer_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clk_pin,
	input  wire logic        gate_pin,
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	output logic             irq,
	output logic      [2:0]  irq_level
);
	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	logic [15:0]  control;
	logic [15:0]  period_value;
	logic [15:0]  count;
	logic [1:0]   irq_status;
	logic [1:0]   irq_mask;
	logic         interrupt_enable_bit;
	logic [2:0]   interrupt_priority;
	timer_ctrl_t  ctrl;
	count_src_t   src;
	power_state_t power;

	logic         ext_level;
	logic         ext_rise;
	logic         gate_level;
	logic         gate_fall;
	logic         async_prev;
	logic         async_rise;
	logic         raw_tick;
	logic         prescale_tick;
	logic         counting;
	logic         match_hit;
	logic         gate_fall_ev;
	logic         access;
	logic         wr;
	logic [31:0]  next_prdata;

	// decoded strobes and next values
	logic         setup_phase;
	logic         hit_control;
	logic         hit_period;
	logic         hit_count;
	logic         hit_status;
	logic         hit_mask;
	logic         hit_config;
	logic         unmapped;
	logic         div_clear;
	logic [1:0]   status_set;
	logic [1:0]   status_clr;
	logic [1:0]   next_irq_status;
	logic         next_irq;

	// ------------------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------------------
	function automatic timer_ctrl_t unpack_ctrl(input logic [15:0] v);
		timer_ctrl_t c;
		c.run       = v[`POS_RUN];
		c.idle_halt = v[`POS_IDLE_HALT];
		c.gated     = v[`POS_GATED];
		c.prescale  = v[`POS_PRESCALE_HI:`POS_PRESCALE_LO];
		c.sync      = v[`POS_SYNC];
		c.clk_src   = v[`POS_CLK_SRC];
		return c;
	endfunction

	// readback rebuilt from fields, so unused bits can only read zero
	function automatic logic [15:0] pack_ctrl(input timer_ctrl_t c);
		logic [15:0] v;
		v = 16'h0000;
		v[`POS_RUN] = c.run;
		v[`POS_IDLE_HALT] = c.idle_halt;
		v[`POS_GATED] = c.gated;
		v[`POS_PRESCALE_HI:`POS_PRESCALE_LO] = c.prescale;
		v[`POS_SYNC] = c.sync;
		v[`POS_CLK_SRC] = c.clk_src;
		return v;
	endfunction

	// one word decode shared by every write strobe
	function automatic logic word_hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	assign ctrl  = unpack_ctrl(control);
	assign power = '{idle: cpu_idle, sleep: cpu_sleep};

	always_comb begin
		if (!ctrl.clk_src) begin
			src = SRC_INTERNAL; // R8
		end else if (ctrl.sync) begin
			src = SRC_EXT_SYNC; // R1
		end else begin
			src = SRC_EXT_ASYNC; // R1
		end
	end

	// ------------------------------------------------------------------------
	// pin inputs
	// ------------------------------------------------------------------------
	pin_sync3 ext_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pin     (ext_clk_pin),
		.level   (ext_level),
		.rise    (ext_rise),
		.fall    ()
	);

	pin_sync3 gate_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pin     (gate_pin),
		.level   (gate_level),
		.rise    (),
		.fall    (gate_fall)
	);

	// async path: edge taken again from the filtered level, same latency;
	// a true second domain is out of scope, so sleep relies on ref_clk running
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			async_prev <= 1'b0;
		end else begin
			async_prev <= ext_level;
		end
	end
	assign async_rise = ext_level && !async_prev;

	// ------------------------------------------------------------------------
	// count clock selection
	// ------------------------------------------------------------------------
	always_comb begin
		case (src)
			SRC_INTERNAL:  raw_tick = 1'b1;       // R8
			SRC_EXT_SYNC:  raw_tick = ext_rise;   // R8 R7
			SRC_EXT_ASYNC: raw_tick = async_rise; // R7
			default:       raw_tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// count qualifiers
	// ------------------------------------------------------------------------
	// run, idle halt, sleep and gate qualify counting
	always_comb begin
		counting = ctrl.run; // R3
		if (power.idle && ctrl.idle_halt) begin
			counting = 1'b0; // R4
		end
		if (power.sleep && src != SRC_EXT_ASYNC) begin
			counting = 1'b0; // R11
		end
		if (ctrl.gated && src == SRC_INTERNAL && !gate_level) begin
			counting = 1'b0; // R5 R15
		end
	end

	// a count write restarts the divider so the new value gets a full period
	assign div_clear = !ctrl.run || hit_count;

	prescaler div (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.clear    (div_clear),
		.tick_in  (raw_tick && counting),
		.prescale (ctrl.prescale),
		.tick_out (prescale_tick)
	); // R6

	// ------------------------------------------------------------------------
	// count and match
	// ------------------------------------------------------------------------
	assign match_hit    = prescale_tick && counting && (count == period_value); // R9
	assign gate_fall_ev = gate_fall && ctrl.gated && src == SRC_INTERNAL && ctrl.run; // R2

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count <= `RST_COUNT;
		end else if (hit_count) begin
			count <= pwdata[15:0];
		end else if (prescale_tick && counting) begin
			if (count == period_value) begin
				count <= 16'h0000; // R14 R12
			end else begin
				count <= count + 16'h0001; // R1
			end
		end
	end

	// ------------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------------
	assign access      = psel && penable && pready;
	assign wr          = access && pwrite;
	assign setup_phase = psel && !pready;
	assign unmapped    = paddr > `OFS_POWER_STATE;

	// ------------------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------------------
	assign hit_control = wr && word_hit(paddr, `OFS_TIMER_CONTROL);
	assign hit_period  = wr && word_hit(paddr, `OFS_PERIOD_VALUE);
	assign hit_count   = wr && word_hit(paddr, `OFS_COUNT_VALUE);
	assign hit_status  = wr && word_hit(paddr, `OFS_IRQ_STATUS);
	assign hit_mask    = wr && word_hit(paddr, `OFS_IRQ_MASK);
	assign hit_config  = wr && word_hit(paddr, `OFS_IRQ_CONFIG);

	// no wait state: ready is registered off the setup cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// ------------------------------------------------------------------------
	// control and period
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			control <= `RST_CONTROL;
		end else if (hit_control) begin
			control <= pwdata[15:0] & `CONTROL_WMASK; // R15 R3
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			period_value <= `RST_PERIOD;
		end else if (hit_period) begin
			period_value <= pwdata[15:0]; // R9
		end
	end

	// ------------------------------------------------------------------------
	// interrupt registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_mask <= 2'h0;
		end else if (hit_mask) begin
			irq_mask <= pwdata[1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			interrupt_enable_bit <= 1'b0;
			interrupt_priority   <= 3'h0;
		end else if (hit_config) begin
			interrupt_enable_bit <= pwdata[0];
			interrupt_priority   <= pwdata[6:4]; // R10
		end
	end

	// ------------------------------------------------------------------------
	// sticky status
	// ------------------------------------------------------------------------
	// a new event beats a same-cycle write-one clear, so no match is lost
	assign status_set      = {gate_fall_ev, match_hit}; // R2 R14
	assign status_clr      = hit_status ? pwdata[1:0] : 2'h0;
	assign next_irq_status = (irq_status & ~status_clr) | status_set;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// ------------------------------------------------------------------------
	// read back
	// ------------------------------------------------------------------------
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`OFS_TIMER_CONTROL: next_prdata = {16'h0000, pack_ctrl(ctrl)}; // R15
			`OFS_PERIOD_VALUE:  next_prdata = {16'h0000, period_value};
			`OFS_COUNT_VALUE:   next_prdata = {16'h0000, count};
			`OFS_IRQ_STATUS:    next_prdata = {30'h0, irq_status};
			`OFS_IRQ_MASK:      next_prdata = {30'h0, irq_mask};
			`OFS_IRQ_CONFIG:    next_prdata = {25'h0, interrupt_priority, 3'h0,
				interrupt_enable_bit};
			`OFS_POWER_STATE:   next_prdata = {30'h0, power};
			default:            next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			// data only while ready stands, zero otherwise
			prdata  <= (setup_phase && !pwrite) ? next_prdata : 32'h0000_0000;
			pslverr <= setup_phase && unmapped;
		end
	end

	// ------------------------------------------------------------------------
	// interrupt output
	// ------------------------------------------------------------------------
	// a masked bit stays pending and raises the line once unmasked
	assign next_irq = interrupt_enable_bit && |(irq_status & irq_mask); // R10

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq       <= 1'b0;
			irq_level <= 3'h0;
		end else begin
			irq       <= next_irq; // R10
			irq_level <= interrupt_priority; // R10
		end
	end
endmodule

// ==== bench/interval_timer_asserts.sv ====
// port checker for the interval timer
`timescale 1ns/1ps
module interval_timer_asserts (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ext_clk_pin,
	input wire logic        gate_pin,
	input wire logic        cpu_idle,
	input wire logic        cpu_sleep,
	input wire logic        irq,
	input wire logic [2:0]  irq_level
);
	// ----
	// bus and interrupt checks
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire        cfg_wr = pready && pwrite && paddr == 12'h014;
	logic [2:0] pri_w;
	// last priority written, so the copy can be judged two cycles on
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pri_w <= 3'h0;
		else if (cfg_wr)
			pri_w <= pwdata[6:4];
	end
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	addr_err_a: assert property (pready |-> pslverr == (paddr > 12'h018))
		else $error("wrong error response");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	ctrl_bits_a: assert property (pready && !pwrite && paddr == 12'h000
		|-> (prdata & 32'hffff5f89) == 32'h0)
		else $error("unused control bit set");
	level_copy_a: assert property (cfg_wr |-> ##2 irq_level == pri_w)
		else $error("priority not forwarded");
	irq_off_a: assert property (cfg_wr && !pwdata[0] |-> ##2 !irq [*2])
		else $error("irq while disabled");
endmodule

bind interval_timer interval_timer_asserts chk (
	.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .ext_clk_pin, .gate_pin, .cpu_idle, .cpu_sleep,
	.irq, .irq_level
);

// ==== bench/interval_timer_tb.sv ====
// self-checking bench for the interval timer
`timescale 1ns/1ps
module interval_timer_tb;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} row_t;
	logic        ref_clk;
	logic        rstn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic        ext_clk_pin = 1'h0;
	logic        gate_pin = 1'h0;
	logic        cpu_idle = 1'h0;
	logic        cpu_sleep = 1'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         irq;
	wire  [2:0]  irq_level;
	logic [31:0] rd_q;
	logic        rd_e;
	int          miscompares = 0;
	int          comparisons = 0;
	int          sh [4] = '{0, 3, 6, 8};
	row_t        rows [7] = '{
		'{12'h000, 32'hffff, 32'ha076, 1'h0}, '{12'h000, 32'h0, 32'h0, 1'h0},
		'{12'h004, 32'h1234, 32'h1234, 1'h0}, '{12'h008, 32'h100, 32'h100, 1'h0},
		'{12'h010, 32'h3, 32'h3, 1'h0}, '{12'h014, 32'h51, 32'h51, 1'h0},
		'{12'h01c, 32'hff, 32'h0, 1'h1}};

	interval_timer DUT (
		.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_clk_pin, .gate_pin, .cpu_idle, .cpu_sleep,
		.irq, .irq_level
	);

	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----
	// tasks
	// ----
	task automatic give_verdict;
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// one idle cycle after each transfer keeps psel from being set twice
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			chk(32'h0, 32'h1);
			give_verdict();
		end
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(rd_q, x);
	endtask
	// pipeline latency leaves a few counts of slack
	task automatic rg(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
		apb(1'h0, a, 32'h0);
		chk(rd_q, (rd_q >= lo && rd_q <= hi) === 1'h1 ? rd_q : lo);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			ext_clk_pin <= 1'h1;
			repeat (6) @(posedge ref_clk);
			ext_clk_pin <= 1'h0;
			repeat (6) @(posedge ref_clk);
		end
	endtask
	task automatic run(input logic [31:0] c, input int n);
		wr(12'h008, 32'h0);
		wr(12'h000, c);
		repeat (n) @(posedge ref_clk);
	endtask

	// ----
	// sequence
	// ----
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'h1;
		@(posedge ref_clk);
		rc(12'h000, 32'h0);
		rc(12'h004, 32'hffff);
		rc(12'h008, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			chk(rd_q, rows[i].x);
			chk({31'h0, rd_e}, {31'h0, rows[i].e});
		end
		for (int i = 0; i < 4; i++) begin
			run(32'h8000 + 32'(i * 16), 2045);
			wr(12'h000, 32'h0);
			rg(12'h008, 32'(2045 >> sh[i]), 32'(2049 >> sh[i]));
		end
		cpu_idle <= 1'h1;
		run(32'ha000, 50);
		rc(12'h008, 32'h0);
		run(32'h8000, 50);
		wr(12'h000, 32'h0);
		rg(12'h008, 32'h32, 32'h35);
		cpu_idle <= 1'h0;
		run(32'h8040, 40);
		rc(12'h008, 32'h0);
		gate_pin <= 1'h1;
		repeat (40) @(posedge ref_clk);
		gate_pin <= 1'h0;
		repeat (10) @(posedge ref_clk);
		wr(12'h000, 32'h0);
		rg(12'h008, 32'h25, 32'h2b);
		rc(12'h00c, 32'h2);
		chk({29'h0, irq_level}, 32'h5);
		wr(12'h010, 32'h0);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		wr(12'h010, 32'h3);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		wr(12'h014, 32'h50);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		wr(12'h014, 32'h51);
		wr(12'h00c, 32'h2);
		rc(12'h00c, 32'h0);
		wr(12'h004, 32'h4);
		run(32'h8000, 30);
		wr(12'h000, 32'h0);
		rg(12'h008, 32'h0, 32'h4);
		rc(12'h00c, 32'h1);
		wr(12'h00c, 32'h1);
		wr(12'h004, 32'hffff);
		run(32'h8046, 0);
		pulses(10);
		wr(12'h000, 32'h0);
		rc(12'h008, 32'ha);
		cpu_sleep <= 1'h1;
		run(32'h8006, 0);
		pulses(3);
		wr(12'h000, 32'h0);
		rc(12'h008, 32'h0);
		run(32'h8002, 0);
		pulses(10);
		wr(12'h000, 32'h0);
		rc(12'h008, 32'ha);
		cpu_sleep <= 1'h0;
		wr(12'h000, 32'h8000);
		rstn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		rstn <= 1'h1;
		@(posedge ref_clk);
		rc(12'h000, 32'h0);
		give_verdict();
	end
endmodule
